// ### rtl/subtract_xor_swap_alu.sv
`timescale 1ns/10ps
module subtract_xor_swap_alu
(
  input  wire logic        pclk,         // Clock
  input  wire logic        presetn,      // Async reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB direction
  input  wire logic [11:0] paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error
  output logic             file_we,      // File write strobe
  output logic      [6:0]  file_waddr,   // File write address
  output logic      [7:0]  file_wdata    // File write data
);
  logic [1:0]  op_r, op_nxt;
  logic        dest_r, dest_nxt;
  logic [6:0]  addr_r, addr_nxt;
  logic [7:0]  wreg_r, wreg_nxt;
  logic [7:0]  file_r, file_nxt;
  logic [7:0]  flags_r, flags_nxt;
  logic [7:0]  res_r, res_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        perr_r, perr_nxt;
  logic        fwe_r, fwe_nxt;
  logic [6:0]  fwa_r, fwa_nxt;
  logic [7:0]  fwd_r, fwd_nxt;
  logic [7:0]  res;
  logic        c_v, dc_v, z_v;
  logic        acc, wr, go, exec;
  logic [1:0]  xop;

  // Access taken once: a high pready blocks a second take
  assign acc  = psel && penable && !pready_r;
  assign wr   = acc && pwrite;
  assign go   = wr && (paddr == alu_pkg::OFF_CTRL) && pwdata[alu_pkg::CTRL_GO_BIT];
  assign xop  = pwdata[alu_pkg::CTRL_OP_LSB +: 2];
  assign exec = go && (xop != alu_pkg::OP_NONE);

  alu_core u_core
  (
    .op     (xop),
    .wval   (wreg_r),
    .fval   (file_r),
    .res    (res),
    .c_out  (c_v),
    .dc_out (dc_v),
    .z_out  (z_v)
  );

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == alu_pkg::OFF_CTRL) || (a == alu_pkg::OFF_WREG) || (a == alu_pkg::OFF_FILE)
          || (a == alu_pkg::OFF_STATUS) || (a == alu_pkg::OFF_RESULT);
  endfunction

  // Operation register: holds op, destination and address of the last control word
  always_comb
  begin
    op_nxt   = op_r;
    dest_nxt = dest_r;
    addr_nxt = addr_r;
    if (wr && paddr == alu_pkg::OFF_CTRL)
    begin
      op_nxt   = xop;
      dest_nxt = pwdata[alu_pkg::CTRL_DEST_BIT];
      addr_nxt = pwdata[alu_pkg::CTRL_ADDR_LSB +: 7];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_r   <= alu_pkg::OP_NONE;
      dest_r <= 1'b0;
      addr_r <= alu_pkg::ADDR_RST;
    end
    else
    begin
      op_r   <= op_nxt;
      dest_r <= dest_nxt;
      addr_r <= addr_nxt;
    end
  end

  // Operands, result and flags
  always_comb
  begin
    wreg_nxt  = wreg_r;
    file_nxt  = file_r;
    flags_nxt = flags_r;
    res_nxt   = res_r;
    if (wr && paddr == alu_pkg::OFF_WREG)
      wreg_nxt = pwdata[7:0];
    if (wr && paddr == alu_pkg::OFF_FILE)
      file_nxt = pwdata[7:0];
    if (wr && paddr == alu_pkg::OFF_STATUS)
      flags_nxt = pwdata[7:0];
    // Core sees the operands as they stood before this edge
    if (exec)
    begin
      res_nxt = res;
      // destination 0 is working, 1 is file
      if (!pwdata[alu_pkg::CTRL_DEST_BIT])
        wreg_nxt = res;
      else
        file_nxt = res;
      if (xop == alu_pkg::OP_SUB)
      begin
        flags_nxt[alu_pkg::FLAG_C]  = c_v;
        flags_nxt[alu_pkg::FLAG_DC] = dc_v;
        flags_nxt[alu_pkg::FLAG_Z]  = z_v;
      end
      else if (xop == alu_pkg::OP_XOR)
        flags_nxt[alu_pkg::FLAG_Z] = z_v;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wreg_r  <= alu_pkg::WREG_RST;
      file_r  <= alu_pkg::FILE_RST;
      flags_r <= alu_pkg::FLAGS_RST;
      res_r   <= alu_pkg::RES_RST;
    end
    else
    begin
      wreg_r  <= wreg_nxt;
      file_r  <= file_nxt;
      flags_r <= flags_nxt;
      res_r   <= res_nxt;
    end
  end

  // File port: one-cycle strobe, address and data held for a slow file
  always_comb
  begin
    fwe_nxt = 1'b0;
    fwa_nxt = fwa_r;
    fwd_nxt = fwd_r;
    if (exec && pwdata[alu_pkg::CTRL_DEST_BIT])
    begin
      fwe_nxt = 1'b1;
      fwa_nxt = pwdata[alu_pkg::CTRL_ADDR_LSB +: 7];
      fwd_nxt = res;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fwe_r <= 1'b0;
      fwa_r <= alu_pkg::ADDR_RST;
      fwd_r <= alu_pkg::FILE_RST;
    end
    else
    begin
      fwe_r <= fwe_nxt;
      fwa_r <= fwa_nxt;
      fwd_r <= fwd_nxt;
    end
  end

  // Bus answer: one wait state buys a full cycle for decode
  always_comb
  begin
    prdata_nxt = prdata_r;
    pready_nxt = acc;
    // Unmapped offsets answer with an error, writes there are dropped
    perr_nxt   = acc && !mapped(paddr);
    if (acc && !pwrite)
    begin
      unique case (paddr)
        alu_pkg::OFF_CTRL:   prdata_nxt = {17'h0, addr_r, 5'h00, dest_r, op_r};
        alu_pkg::OFF_WREG:   prdata_nxt = {24'h000000, wreg_r};
        alu_pkg::OFF_FILE:   prdata_nxt = {24'h000000, file_r};
        alu_pkg::OFF_STATUS: prdata_nxt = {24'h000000, flags_r};
        alu_pkg::OFF_RESULT: prdata_nxt = {24'h000000, res_r};
        default:             prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      perr_r   <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      perr_r   <= perr_nxt;
    end
  end

  // Every output is a register, so no decode glitch reaches a pin
  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = perr_r;
  assign file_we    = fwe_r;
  assign file_waddr = fwa_r;
  assign file_wdata = fwd_r;
endmodule

// ### rtl/alu_pkg.sv
package alu_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;

  // Register byte addresses
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_WREG   = 12'h004;
  localparam logic [11:0] OFF_FILE   = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_RESULT = 12'h010;

  // Control word fields
  localparam int unsigned CTRL_OP_LSB   = 0;
  localparam int unsigned CTRL_DEST_BIT = 2;
  localparam int unsigned CTRL_GO_BIT   = 3;
  localparam int unsigned CTRL_ADDR_LSB = 8;

  // Flag positions in status word
  localparam int unsigned FLAG_C  = 0;
  localparam int unsigned FLAG_DC = 1;
  localparam int unsigned FLAG_Z  = 2;

  localparam logic [7:0] WREG_RST  = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] FILE_RST  = 8'h00;
  localparam logic [7:0] RES_RST   = 8'h00;
  localparam logic [6:0] ADDR_RST  = 7'h00;

  typedef enum logic [1:0]
  {
    OP_SUB  = 2'h0,
    OP_XOR  = 2'h1,
    OP_SWAP = 2'h2,
    OP_NONE = 2'h3
  } op_e;

endpackage

// ### rtl/alu_core.sv
`timescale 1ns/10ps
module alu_core
(
  input  wire logic [1:0] op,       // Operation code
  input  wire logic [7:0] wval,     // Working register value
  input  wire logic [7:0] fval,     // File register value
  output logic      [7:0] res,      // Result
  output logic            c_out,    // Carry (no borrow)
  output logic            dc_out,   // Digit carry (no borrow)
  output logic            z_out     // Result zero
);
  logic [8:0] diff;
  logic [4:0] ldiff;

  always_comb
  begin
    diff   = {1'b0, fval} + {1'b0, ~wval} + 9'h001;
    ldiff  = {1'b0, fval[3:0]} + {1'b0, ~wval[3:0]} + 5'h01;
    c_out  = diff[8];
    dc_out = ldiff[4];
    unique case (op)
      alu_pkg::OP_SUB:  res = diff[7:0];
      alu_pkg::OP_XOR:  res = wval ^ fval;
      alu_pkg::OP_SWAP: res = {fval[3:0], fval[7:4]};
      default:          res = fval;
    endcase
    z_out = (res == 8'h00);
  end
endmodule

// ### dv/alu_chk_assertions.sv
`timescale 1ns/10ps
module alu_chk
(
  input wire logic        pclk,       // Clk
  input wire logic        presetn,    // Rst
  input wire logic        psel,       // Sel
  input wire logic        penable,    // En
  input wire logic        pwrite,     // Dir
  input wire logic [11:0] paddr,      // Addr
  input wire logic [31:0] pwdata,     // Wdata
  input wire logic        pready,     // Rdy
  input wire logic        file_we,    // Strobe
  input wire logic [6:0]  file_waddr, // Faddr
  input wire logic [7:0]  file_wdata  // Fdata
);
  logic [7:0] fv_r;
  logic [7:0] fv_nxt;
  logic [7:0] wv_r;
  logic [7:0] wv_nxt;
  logic [7:0] ex_res;
  wire        tk = psel && penable && !pready && pwrite;
  wire        go = tk && paddr == alu_pkg::OFF_CTRL && pwdata[3] && pwdata[1:0] != 2'h3;
  // Reference result from the shadowed operands
  assign ex_res = (pwdata[1:0] == 2'h0) ? fv_r - wv_r :
                  (pwdata[1:0] == 2'h1) ? wv_r ^ fv_r : {fv_r[3:0], fv_r[7:4]};
  // Shadows follow bus writes and the reference result, never the outputs
  assign fv_nxt = (tk && paddr == alu_pkg::OFF_FILE) ? pwdata[7:0] : (go && pwdata[2]) ? ex_res : fv_r;
  assign wv_nxt = (tk && paddr == alu_pkg::OFF_WREG) ? pwdata[7:0] : (go && !pwdata[2]) ? ex_res : wv_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      fv_r <= alu_pkg::FILE_RST;
      wv_r <= alu_pkg::WREG_RST;
    end
    else
    begin
      fv_r <= fv_nxt;
      wv_r <= wv_nxt;
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  strobe_cause_a: assert property (file_we |-> $past(go && pwdata[2]))
    else $error("file strobe without cause");
  w_dest_a: assert property (go && !pwdata[2] |=> !file_we)
    else $error("file strobe with dest 0");
  file_addr_a: assert property (go && pwdata[2] |=> file_we && file_waddr == $past(pwdata[14:8]))
    else $error("file write missing");
  swap_data_a: assert property (go && pwdata[2] && pwdata[1:0] == 2'h2 |=>
    file_wdata == {$past(fv_r[3:0]), $past(fv_r[7:4])})
    else $error("swap data wrong");
  sub_data_a: assert property (go && pwdata[2] && pwdata[1:0] == 2'h0 |=>
    file_wdata == $past(fv_r) - $past(wv_r))
    else $error("subtract data wrong");
  xor_data_a: assert property (go && pwdata[2] && pwdata[1:0] == 2'h1 |=>
    file_wdata == ($past(wv_r) ^ $past(fv_r)))
    else $error("xor data wrong");
  ready_time_a: assert property (psel && penable && !pready |=> pready)
    else $error("late ready");
endmodule

// ### dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, d, pready, pslverr, file_we;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [6:0]  file_waddr;
  logic [7:0]  file_wdata, w, f, fl, r = 8'h00;
  logic [1:0]  op;
  logic [33:0] nt, q[$];
  logic [14:0] fq[$];
  integer      seed = 83, failures = 0, n_tests = 0;
  always #50 pclk = ~pclk;
  subtract_xor_swap_alu i_subtract_xor_swap_alu (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task finish_test();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Reads carry the expected word in dt
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dt, input logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    q.push_back({wr, e, dt});
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge pclk)
  begin
    if (pready === 1'b1)
    begin
      nt = q.pop_front();
      if (!nt[33]) chk("prdata", prdata, nt[31:0]);
      chk("pslverr", {31'h0, pslverr}, {31'h0, nt[32]});
    end
    if (file_we === 1'b1) chk("file_write", {17'h0, file_waddr, file_wdata}, {17'h0, fq.pop_front()});
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, alu_pkg::OFF_WREG, 32'h0, 1'b0);
    apb(1'b0, 12'h014, 32'h0, 1'b1);
    for (int i = 0; i < 32; i++)
    begin
      op = i[1:0];
      d = i[2];
      w = 8'($random(seed));
      f = (i < 8) ? w : 8'($random(seed));
      fl = {5'h0, 3'($random(seed))};
      apb(1'b1, alu_pkg::OFF_WREG, {24'h0, w}, 1'b0);
      apb(1'b1, alu_pkg::OFF_FILE, {24'h0, f}, 1'b0);
      apb(1'b1, alu_pkg::OFF_STATUS, {24'h0, fl}, 1'b0);
      // Sub flags: C and DC mean no borrow
      if (op == 2'h0)
      begin
        r = f - w;
        fl = {5'h0, r == 8'h00, f[3:0] >= w[3:0], f >= w};
      end
      else if (op == 2'h1)
      begin
        r = w ^ f;
        fl[2] = r == 8'h00;
      end
      else if (op == 2'h2)
        r = {f[3:0], f[7:4]};
      if (d && op != 2'h3) fq.push_back({i[6:0], r});
      apb(1'b1, alu_pkg::OFF_CTRL, {17'h0, i[6:0], 4'h0, 1'b1, d, op}, 1'b0);
      apb(1'b0, alu_pkg::OFF_RESULT, {24'h0, r}, 1'b0);
      apb(1'b0, alu_pkg::OFF_WREG, {24'h0, (d || op == 2'h3) ? w : r}, 1'b0);
      apb(1'b0, alu_pkg::OFF_FILE, {24'h0, (d && op != 2'h3) ? r : f}, 1'b0);
      apb(1'b0, alu_pkg::OFF_STATUS, {24'h0, fl}, 1'b0);
      apb(1'b0, alu_pkg::OFF_CTRL, {17'h0, i[6:0], 5'h0, d, op}, 1'b0);
    end
    // Mid-run reset must bring every register back
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, alu_pkg::OFF_CTRL, {30'h0, alu_pkg::OP_NONE}, 1'b0);
    apb(1'b0, alu_pkg::OFF_WREG, {24'h0, alu_pkg::WREG_RST}, 1'b0);
    apb(1'b0, alu_pkg::OFF_FILE, {24'h0, alu_pkg::FILE_RST}, 1'b0);
    apb(1'b0, alu_pkg::OFF_STATUS, {24'h0, alu_pkg::FLAGS_RST}, 1'b0);
    apb(1'b0, alu_pkg::OFF_RESULT, {24'h0, alu_pkg::RES_RST}, 1'b0);
    // Let the monitor drain before judging
    repeat (2) @(posedge pclk);
    chk("pending", q.size() + fq.size(), 0);
    finish_test();
  end
  initial
  begin
    #1000000;
    failures++;
    finish_test();
  end
endmodule
bind subtract_xor_swap_alu alu_chk i_alu_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .file_we(file_we),
  .file_waddr(file_waddr), .file_wdata(file_wdata));
